/* File: logic/cdoc_regs.vh */
`ifndef CDOC_REGS_VH
`define CDOC_REGS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CDOC_OFS_APE 8'h00
`define CDOC_OFS_UV_THR 8'h04
`define CDOC_OFS_OV_THR 8'h08
`define CDOC_OFS_UV_REF 8'h0C
`define CDOC_OFS_OV_REF 8'h10
`define CDOC_OFS_STATUS 8'h14

// ------------------------------------------------------------
// enable register fields
// ------------------------------------------------------------
`define CDOC_BIT_OV_EN 0
`define CDOC_BIT_UV_EN 1
`define CDOC_BIT_RAMP_POINT_SELECT 2
`define CDOC_BIT_MEAS 3
`define CDOC_BIT_LO_DIS 4
`define CDOC_BIT_HI_DIS 5
`define CDOC_BIT_BOOST 6
`define CDOC_BIT_RECT 7
`define CDOC_RST_APE 8'h30

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define CDOC_ST_UV_ACT 0
`define CDOC_ST_OV_ACT 1
`define CDOC_ST_BUSY 2
`define CDOC_ST_HS 3
`define CDOC_ST_LS 4
`define CDOC_ST_DE_HOLD 5

// ------------------------------------------------------------
// other reset values and bus codes
// ------------------------------------------------------------
`define CDOC_RST_UV_THR 8'h00
`define CDOC_RST_OV_THR 8'hFF
`define CDOC_RST_REF 8'h00
`define CDOC_HTRANS_NONSEQ 2'h2
`define CDOC_HTRANS_SEQ 2'h3
`define CDOC_HRESP_OKAY 1'h0
`define CDOC_ADC_CH_RAMP 5'h08

`endif

/* File: logic/cdoc_sync2.v */
`timescale 1ns/1ps
// two flop synchroniser for independent pin levels
module cdoc_sync2 #(
  parameter W = 1
) (
  input wire hclk,
  input wire hresetn,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // first stage feeds only the second stage
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

/* File: logic/cdoc_cmp.v */
`timescale 1ns/1ps
// registered window comparator on the sampled output voltage
module cdoc_cmp #(
  parameter W = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire [W-1:0] vout_code,
  input wire [W-1:0] uv_threshold,
  input wire [W-1:0] ov_threshold,
  output reg below_uv_q,
  output reg above_ov_q
);
  // flags follow the voltage both ways, so they drop once it recovers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      below_uv_q <= 1'b0;
      above_ov_q <= 1'b0;
    end else begin
      below_uv_q <= (vout_code < uv_threshold);
      above_ov_q <= (vout_code > ov_threshold);
    end
  end
endmodule

/* File: logic/cdoc_top.v */
`timescale 1ns/1ps
`include "cdoc_regs.vh"

module cdoc_top #(
  parameter VW = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  input wire [VW-1:0] vout_code,
  input wire pwm_high_pin,
  input wire pwm_low_pin,
  input wire ls_zero_pin,
  input wire cycle_start_pin,
  input wire meas_done_pin,
  output reg high_side_gate_drive,
  output reg low_side_gate_drive,
  output reg diode_emulation_q,
  output reg boost_mode_q,
  output reg efficiency_measure_pulse,
  output reg ramp_peak_select_q,
  output reg [4:0] adc_ramp_channel,
  output reg [VW-1:0] uv_reference_level,
  output reg [VW-1:0] ov_reference_level
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  reg [7:0] ape_q;
  reg [VW-1:0] uv_thr_q;
  reg [VW-1:0] ov_thr_q;
  reg [VW-1:0] uv_ref_q;
  reg [VW-1:0] ov_ref_q;
  reg busy_q;
  reg de_hold_q;
  reg cyc_prev_q;
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  reg [31:0] rd_d;
  reg hs_d;
  reg ls_d;
  wire [4:0] pins_s;
  wire pwm_high_s;
  wire pwm_low_s;
  wire ls_zero_s;
  wire cycle_start_s;
  wire meas_done_s;
  wire below_uv;
  wire above_ov;
  wire ov_act;
  wire uv_act;
  wire cycle_edge;
  wire addr_ok;
  wire wr_ape;
  wire start_wr;
  wire [7:0] status_w;
  wire ov_en;
  wire uv_en;
  wire ramp_point_select_sel;
  wire lo_dis;
  wire hi_dis;
  wire boost_sel;
  wire rect_de;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // word offset hits a register
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `CDOC_OFS_APE) || (a == `CDOC_OFS_UV_THR) || (a == `CDOC_OFS_OV_THR) ||
               (a == `CDOC_OFS_UV_REF) || (a == `CDOC_OFS_OV_REF) || (a == `CDOC_OFS_STATUS);
    end
  endfunction

  // widen a threshold field onto the data bus
  function [31:0] widen;
    input [VW-1:0] v;
    begin
      widen = {{(32-VW){1'b0}}, v};
    end
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers and comparator
  // ------------------------------------------------------------
  // asynchronous converter pins pass two flops
  cdoc_sync2 #(
    .W(5)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({meas_done_pin, cycle_start_pin, ls_zero_pin, pwm_low_pin, pwm_high_pin}),
    .sync_out(pins_s)
  );

  assign pwm_high_s = pins_s[0];
  assign pwm_low_s = pins_s[1];
  assign ls_zero_s = pins_s[2];
  assign cycle_start_s = pins_s[3];
  assign meas_done_s = pins_s[4];

  cdoc_cmp #(
    .W(VW)
  ) u_cmp (
    .hclk(hclk),
    .hresetn(hresetn),
    .vout_code(vout_code),
    .uv_threshold(uv_thr_q),
    .ov_threshold(ov_thr_q),
    .below_uv_q(below_uv),
    .above_ov_q(above_ov)
  );

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  // address phase qualifier for a valid transfer
  assign addr_ok = hsel && hready && (htrans == `CDOC_HTRANS_NONSEQ || htrans == `CDOC_HTRANS_SEQ);
  assign wr_ape = wr_pend_q && (wr_addr_q == `CDOC_OFS_APE);
  // start is a strobe: seen only in the write data phase, never replayed
  assign start_wr = wr_ape && hwdata[`CDOC_BIT_MEAS];

  // capture write address, answer with zero wait states
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= `CDOC_HRESP_OKAY;
    end else begin
      wr_pend_q <= addr_ok && hwrite && mapped(haddr);
      wr_addr_q <= haddr;
      hreadyout <= 1'b1;
      hresp <= `CDOC_HRESP_OKAY;
    end
  end

  // status word built from live block state
  assign status_w = {2'b00, de_hold_q, low_side_gate_drive, high_side_gate_drive, busy_q, ov_act, uv_act};

  // read mux, unmapped offsets read zero
  always @* begin
    rd_d = 32'h0000_0000;
    case (haddr)
      // start bit reads busy, so software can poll for the end
      `CDOC_OFS_APE: rd_d = {24'h000000, ape_q[7:4], busy_q, ape_q[2:0]};
      `CDOC_OFS_UV_THR: rd_d = widen(uv_thr_q);
      `CDOC_OFS_OV_THR: rd_d = widen(ov_thr_q);
      `CDOC_OFS_UV_REF: rd_d = widen(uv_ref_q);
      `CDOC_OFS_OV_REF: rd_d = widen(ov_ref_q);
      `CDOC_OFS_STATUS: rd_d = {24'h000000, status_w};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // read data registered for the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rd_d;
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  // disables reset set
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ape_q <= `CDOC_RST_APE;
      uv_thr_q <= `CDOC_RST_UV_THR;
      ov_thr_q <= `CDOC_RST_OV_THR;
      uv_ref_q <= `CDOC_RST_REF;
      ov_ref_q <= `CDOC_RST_REF;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        `CDOC_OFS_APE: ape_q <= hwdata[7:0];
        `CDOC_OFS_UV_THR: uv_thr_q <= hwdata[VW-1:0];
        `CDOC_OFS_OV_THR: ov_thr_q <= hwdata[VW-1:0];
        `CDOC_OFS_UV_REF: uv_ref_q <= hwdata[VW-1:0];
        `CDOC_OFS_OV_REF: ov_ref_q <= hwdata[VW-1:0];
        default: ape_q <= ape_q;
      endcase
    end
  end

  // ------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------
  // named views of the enable register bits
  assign ov_en = ape_q[`CDOC_BIT_OV_EN];
  assign uv_en = ape_q[`CDOC_BIT_UV_EN];
  assign ramp_point_select_sel = ape_q[`CDOC_BIT_RAMP_POINT_SELECT];
  assign lo_dis = ape_q[`CDOC_BIT_LO_DIS];
  assign hi_dis = ape_q[`CDOC_BIT_HI_DIS];
  assign boost_sel = ape_q[`CDOC_BIT_BOOST];
  assign rect_de = ape_q[`CDOC_BIT_RECT];

  // ------------------------------------------------------------
  // efficiency measurement
  // ------------------------------------------------------------
  // start sets busy, set beats done
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q <= 1'b0;
      efficiency_measure_pulse <= 1'b0;
    end else begin
      efficiency_measure_pulse <= start_wr;
      if (start_wr) begin
        busy_q <= 1'b1;
      end else if (meas_done_s) begin
        busy_q <= 1'b0;
      end
    end
  end

  // ramp_point_select chooses ramp point while idle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ramp_peak_select_q <= 1'b0;
      adc_ramp_channel <= `CDOC_ADC_CH_RAMP;
    end else begin
      adc_ramp_channel <= `CDOC_ADC_CH_RAMP;
      // frozen while busy so a running measurement keeps its ramp point
      if (!busy_q) begin
        ramp_peak_select_q <= ramp_point_select_sel;
      end
    end
  end

  // ------------------------------------------------------------
  // mode outputs and analog references
  // ------------------------------------------------------------
  // mode and topology straight from flops
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      diode_emulation_q <= 1'b0;
      boost_mode_q <= 1'b0;
      uv_reference_level <= `CDOC_RST_REF;
      ov_reference_level <= `CDOC_RST_REF;
    end else begin
      diode_emulation_q <= rect_de;
      boost_mode_q <= boost_sel;
      uv_reference_level <= uv_ref_q;
      ov_reference_level <= ov_ref_q;
    end
  end

  // ------------------------------------------------------------
  // diode emulation hold
  // ------------------------------------------------------------
  assign cycle_edge = cycle_start_s && !cyc_prev_q;

  // zero crossing ends low drive until next cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_prev_q <= 1'b0;
      de_hold_q <= 1'b0;
    end else begin
      cyc_prev_q <= cycle_start_s;
      // zero crossing wins over a cycle start in the same clock
      if (!rect_de) begin
        de_hold_q <= 1'b0;
      end else if (ls_zero_s && low_side_gate_drive) begin
        de_hold_q <= 1'b1;
      end else if (cycle_edge) begin
        de_hold_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // gate drive override
  // ------------------------------------------------------------
  // overvoltage override when enabled
  assign ov_act = ov_en && above_ov;
  assign uv_act = uv_en && below_uv && !ov_act;

  // next drive levels, disables have last word
  always @* begin
    hs_d = (uv_act || (pwm_high_s && !de_hold_q)) && !ov_act;
    ls_d = pwm_low_s && !uv_act && !ov_act && !de_hold_q && !hs_d;
    if (hi_dis) begin
      hs_d = 1'b0;
    end
    if (lo_dis) begin
      ls_d = 1'b0;
    end
  end

  // drives registered, both off at reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_side_gate_drive <= 1'b0;
      low_side_gate_drive <= 1'b0;
    end else begin
      high_side_gate_drive <= hs_d;
      low_side_gate_drive <= ls_d;
    end
  end

endmodule

/* File: verif/cdoc_switch_model.sv */
`timescale 1ns/1ps
// ----------------
// power stage seen by the gate drivers
// ----------------
// the low switch voltage falls to zero once the low drive has conducted for three cycles
module cdoc_switch_model (
  input wire hclk,
  input wire hresetn,
  input wire low_drive,
  output wire ls_zero
);
  reg [1:0] cnt_q;
  // count conduction time of the low switch
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 2'h0;
    end else if (!low_drive) begin
      cnt_q <= 2'h0;
    end else if (cnt_q != 2'h3) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
  assign ls_zero = (cnt_q == 2'h3);
endmodule

/* File: verif/cdoc_monitor.sv */
`timescale 1ns/1ps
// ----------------
// drive override checker
// ----------------
module cdoc_monitor #(
  parameter VW = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [VW-1:0] vout_code,
  input wire high_side_gate_drive,
  input wire low_side_gate_drive,
  input wire diode_emulation_q,
  input wire boost_mode_q,
  input wire efficiency_measure_pulse,
  input wire [4:0] adc_ramp_channel
);
  reg w_q;
  reg [7:0] a_q;
  reg [7:0] pe_q;
  reg [7:0] uv_q;
  reg [7:0] ov_q;
  // shadow copies of written control registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      w_q <= 1'b0;
      a_q <= 8'h00;
      pe_q <= 8'h30;
      uv_q <= 8'h00;
      ov_q <= 8'hFF;
    end else begin
      w_q <= hsel && hready && htrans[1] && hwrite;
      a_q <= haddr;
      if (w_q && a_q == 8'h00) pe_q <= hwdata[7:0];
      if (w_q && a_q == 8'h04) uv_q <= hwdata[7:0];
      if (w_q && a_q == 8'h08) ov_q <= hwdata[7:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // write to the enable register, ending in its data phase
  sequence ape_wr_s;
    hsel && hready && htrans[1] && hwrite && haddr == 8'h00 ##1 1'b1;
  endsequence
  ov_force_a: assert property ((pe_q[0] && vout_code > ov_q) [*3] |->
    !high_side_gate_drive && !low_side_gate_drive) else $error("overvoltage did not cut drives");
  uv_force_a: assert property ((pe_q[1] && !pe_q[5] && vout_code < uv_q && !(pe_q[0] && vout_code > ov_q)) [*3]
    |-> high_side_gate_drive && !low_side_gate_drive) else $error("undervoltage did not force high side");
  hs_disable_a: assert property (pe_q[5] [*2] |-> !high_side_gate_drive)
    else $error("high side driven while disabled");
  ls_disable_a: assert property (pe_q[4] [*2] |-> !low_side_gate_drive)
    else $error("low side driven while disabled");
  drives_excl_a: assert property (!(high_side_gate_drive && low_side_gate_drive))
    else $error("both drives on");
  meas_pulse_a: assert property (ape_wr_s ##0 hwdata[3] |=>
    efficiency_measure_pulse ##1 !efficiency_measure_pulse) else $error("start pulse wrong");
  mode_copy_a: assert property (ape_wr_s |=> ##1 {diode_emulation_q, boost_mode_q} == $past(hwdata[7:6], 2))
    else $error("mode outputs not updated");
  adc_channel_a: assert property (adc_ramp_channel == 5'h08)
    else $error("ramp channel wrong");
endmodule

bind cdoc_top cdoc_monitor #(.VW(VW)) cdoc_monitor_inst (.*);

/* File: verif/test_converter_driver_override_control.sv */
`timescale 1ns/1ps
// ----------------
// register bank and override bench
// ----------------
module test_converter_driver_override_control;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg [7:0] haddr = 8'h00;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [2:0] hsize = 3'h2;
  reg [31:0] hwdata = 32'h0;
  reg [7:0] vout = 8'h80;
  reg ph = 1'b0;
  reg pl = 1'b0;
  reg cs = 1'b0;
  reg md = 1'b0;
  reg [31:0] r;
  wire hready, hresp, hs, ls, lz, de, bm, mp, rp;
  wire [4:0] ch;
  wire [7:0] uvr, ovr;
  wire [31:0] rd;
  integer error_cnt = 0;
  integer total_checks = 0;
  integer i;
  always #10 hclk = ~hclk;
  cdoc_top cdoc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(rd),
    .hresp(hresp), .vout_code(vout), .pwm_high_pin(ph), .pwm_low_pin(pl), .ls_zero_pin(lz),
    .cycle_start_pin(cs), .meas_done_pin(md), .high_side_gate_drive(hs), .low_side_gate_drive(ls),
    .diode_emulation_q(de), .boost_mode_q(bm), .efficiency_measure_pulse(mp), .ramp_peak_select_q(rp),
    .adc_ramp_channel(ch), .uv_reference_level(uvr), .ov_reference_level(ovr));
  cdoc_switch_model cdoc_switch_model_inst (.hclk(hclk), .hresetn(hresetn), .low_drive(ls), .ls_zero(lz));
  // compare and count
  task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // one single transfer, read data left in r
  task bus(input [7:0] a, input w, input [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      r = rd;
    end
  endtask
  task rdc(input [63:0] nm, input [7:0] a, input [31:0] exp);
    begin
      bus(a, 1'b0, 32'h0);
      chk(nm, r, exp);
    end
  endtask
  // wait n edges, then look at settled outputs on the falling edge
  task wt(input integer n);
    begin
      repeat (n) @(posedge hclk);
      @(negedge hclk);
    end
  endtask
  // converter pins and voltage, changed just after a rising edge
  task pins(input p_h, input p_l, input p_c, input p_m, input [7:0] v);
    begin
      @(posedge hclk);
      ph <= p_h;
      pl <= p_l;
      cs <= p_c;
      md <= p_m;
      vout <= v;
    end
  endtask
  task print_verdict;
    begin
      if (error_cnt == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  // watchdog, far beyond the few hundred cycles of the tests
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    print_verdict;
  end
  // main sequence
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("apen", 8'h00, 32'h30);
    rdc("ovthr", 8'h08, 32'hFF);
    wt(1);
    chk("drv", {hs, ls}, 32'h0);
    chk("hresp", hresp, 32'h0);
    bus(8'h20, 1'b1, 32'hFF);
    rdc("unmap", 8'h20, 32'h0);
    bus(8'h04, 1'b1, 32'h40);
    bus(8'h08, 1'b1, 32'hC0);
    bus(8'h0C, 1'b1, 32'h55);
    bus(8'h10, 1'b1, 32'hAA);
    rdc("uvthr", 8'h04, 32'h40);
    chk("refs", {ovr, uvr}, 32'hAA55);
    bus(8'h00, 1'b1, 32'h00);
    pins(1'b1, 1'b0, 1'b0, 1'b0, 8'h80);
    wt(5);
    chk("hs", {hs, ls}, 32'h2);
    pins(1'b0, 1'b1, 1'b0, 1'b0, 8'h80);
    wt(5);
    chk("ls", {hs, ls}, 32'h1);
    pins(1'b0, 1'b1, 1'b0, 1'b0, 8'h20);
    wt(4);
    chk("uvoff", {hs, ls}, 32'h1);
    bus(8'h00, 1'b1, 32'h02);
    wt(3);
    chk("uvon", {hs, ls}, 32'h2);
    bus(8'h00, 1'b1, 32'h22);
    wt(3);
    chk("uvdis", {hs, ls}, 32'h0);
    pins(1'b1, 1'b0, 1'b0, 1'b0, 8'hD0);
    bus(8'h00, 1'b1, 32'h00);
    wt(4);
    chk("ovoff", {hs, ls}, 32'h2);
    bus(8'h00, 1'b1, 32'h01);
    wt(3);
    chk("ovon", {hs, ls}, 32'h0);
    bus(8'h04, 1'b1, 32'hF0);
    bus(8'h00, 1'b1, 32'h03);
    wt(3);
    chk("ovuv", {hs, ls}, 32'h0);
    pins(1'b0, 1'b0, 1'b0, 1'b0, 8'h80);
    for (i = 0; i < 4; i = i + 1) begin
      bus(8'h00, 1'b1, (i << 6) | 32'h30);
      wt(2);
      chk("mode", {de, bm}, i);
      rdc("apen", 8'h00, (i << 6) | 32'h30);
    end
    bus(8'h00, 1'b1, 32'h34);
    wt(2);
    chk("peak", rp, 32'h1);
    bus(8'h00, 1'b1, 32'h30);
    wt(2);
    chk("valley", rp, 32'h0);
    bus(8'h00, 1'b1, 32'h38);
    rdc("busy", 8'h00, 32'h38);
    bus(8'h00, 1'b1, 32'h34);
    wt(2);
    chk("spanbsy", rp, 32'h0);
    pins(1'b0, 1'b0, 1'b0, 1'b1, 8'h80);
    wt(4);
    pins(1'b0, 1'b0, 1'b0, 1'b0, 8'h80);
    rdc("idle", 8'h00, 32'h34);
    wt(2);
    chk("spanidl", rp, 32'h1);
    bus(8'h00, 1'b1, 32'h80);
    pins(1'b0, 1'b1, 1'b0, 1'b0, 8'h80);
    wt(14);
    chk("deend", {hs, ls}, 32'h0);
    pins(1'b1, 1'b0, 1'b0, 1'b0, 8'h80);
    wt(5);
    chk("dehold", {hs, ls}, 32'h0);
    pins(1'b1, 1'b0, 1'b1, 1'b0, 8'h80);
    wt(6);
    chk("denext", {hs, ls}, 32'h2);
    print_verdict;
  end
endmodule
